// ---- src/rx_checksum_defines.vh ----
// constants for the receive checksum offload block
// assumes an apb slave with byte addresses and 32-bit data
`ifndef RX_CHECKSUM_DEFINES_VH
`define RX_CHECKSUM_DEFINES_VH

// register byte addresses
`define ADDR_CTRL 16'h5000
`define ADDR_IRQ_STATUS 16'h5004
`define ADDR_IRQ_ENABLE 16'h5008
`define ADDR_IRQ_CLEAR 16'h500c
`define ADDR_LAST_RESULT 16'h5010
`define ADDR_RX_CONFIG 16'h5014

// control register fields
`define CTRL_START_HI 7
`define CTRL_START_LO 0
`define CTRL_IP_EN 8
`define CTRL_L4_EN 9
`define CTRL_PKT_DIS 13
`define CTRL_START_RST 8'h00
`define CTRL_BIT_RST 1'b0

// config register field
`define CFG_STRIP_FCS 0

// interrupt status layout
`define IRQ_COUNT 2
`define IRQ_FRAME_DONE 0
`define IRQ_CSUM_ERR 1

// last result layout
`define RES_ERR_BIT 16

// frame layout
`define FCS_LEN 3'h4
`define POS_TYPE_HI 16'h000c
`define POS_TYPE_LO 16'h000d
`define POS_SNAP_FIRST 16'h000e
`define POS_SNAP_LAST 16'h0013
`define POS_SNAP_TYPE_HI 16'h0014
`define POS_SNAP_TYPE_LO 16'h0015
`define IP_OFF_ETH2 16'h000e
`define IP_OFF_SNAP 16'h0016
`define ETYPE_IPV4 16'h0800
`define MAX_LEN_FIELD 16'h05dc
`define SNAP_LLC_B0 8'haa
`define SNAP_LLC_B2 8'h03
`define SNAP_OUI_B 8'h00

// ip header offsets relative to header start
`define IPR_VER_IHL 16'h0000
`define IPR_LEN_HI 16'h0002
`define IPR_LEN_LO 16'h0003
`define IPR_FRAG_HI 16'h0006
`define IPR_FRAG_LO 16'h0007
`define IPR_PROTO 16'h0009
`define IPR_ADDR_FIRST 16'h000c
`define IPR_ADDR_LAST 16'h0013
`define IP_VERSION4 4'h4
`define IP_MIN_IHL 4'h5
`define PROTO_TCP 8'h06
`define PROTO_UDP 8'h11
`define UDP_CSUM_HI 16'h0006
`define UDP_CSUM_LO 16'h0007
`define SUM_GOOD 16'hffff

// state codes
`define ST_RUN 2'h0
`define ST_FLUSH 2'h1
`define ST_PSEUDO 2'h2
`define ST_REPORT 2'h3

`endif

// ---- src/csum_acc.v ----
// one's complement 16-bit accumulator fed byte by byte or word by word
// assumes clear, byte_en and word_en are never high together with each other
`timescale 1ns/10ps
module csum_acc (
   input wire pclk, // core clock
   input wire presetn, // async reset, active low
   input wire clear, // start a new sum
   input wire byte_en, // add byte_data at the current parity
   input wire [7:0] byte_data, // byte to add
   input wire word_en, // add a whole word
   input wire [15:0] word_data, // word to add
   output wire [15:0] sum // running sum
);
   reg [15:0] sum_r;
   reg odd_r;
   reg [15:0] addend;
   reg [16:0] raw;

   always @* begin
      if (word_en) begin
         addend = word_data;
      end else if (odd_r) begin
         addend = {8'h00, byte_data};
      end else begin
         addend = {byte_data, 8'h00};
      end
      raw = {1'b0, sum_r} + {1'b0, addend};
   end

   // big-endian words, end-around carry, odd tail padded by zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum_r <= 16'h0000;
         odd_r <= 1'b0;
      end else if (clear) begin
         sum_r <= 16'h0000;
         odd_r <= 1'b0;
      end else if (byte_en || word_en) begin
         sum_r <= raw[15:0] + {15'h0000, raw[16]};
         if (byte_en) begin
            odd_r <= ~odd_r;
         end
      end
   end

   assign sum = sum_r;
endmodule

// ---- src/irq_status.v ----
// sticky event status with enable and write-one-to-clear, one level interrupt
// assumes events are single-cycle pulses from the same clock
`timescale 1ns/10ps
module irq_status (
   input wire pclk, // core clock
   input wire presetn, // async reset, active low
   input wire [1:0] event_set, // event pulses
   input wire enable_wr, // write strobe for enable
   input wire clear_wr, // write strobe for clear
   input wire [1:0] wdata, // write data
   output wire [1:0] status, // sticky status
   output wire [1:0] enable, // enable mask
   output wire irq // level interrupt
);
   reg [1:0] status_r;
   reg [1:0] enable_r;

   // a set in the cycle of its clear wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= 2'h0;
         enable_r <= 2'h0;
      end else begin
         status_r <= (status_r & ~({2{clear_wr}} & wdata)) | event_set;
         if (enable_wr) begin
            enable_r <= wdata;
         end
      end
   end

   assign status = status_r;
   assign enable = enable_r;
   assign irq = |(status_r & enable_r);
endmodule

// ---- src/rx_checksum_offload.v ----
// receive checksum offload: packet sum, ip header check, tcp/udp check
// assumes a byte stream after vlan removal with the fcs still attached,
// one frame after another, and an apb master on the core clock
// Overview of operation
// - start byte from control bits 7:0, zero first
// - packet sum from start byte, after vlan removal
// - fcs left out when strip enable set
// - bit 8 enables ip header check
// - bit 9 enables tcp/udp check
// - error flag if either enabled check fails
// - no checks enabled gives error flag zero
// - three sums: packet, ip header, tcp/udp
// - ethernet ii and snap frames handled
// - control fields reset zero, bits 11:10 reserved
// - packet sum reported in the descriptor only while disable bit clear
`timescale 1ns/10ps
`include "rx_checksum_defines.vh"
module rx_checksum_offload (
   input wire pclk, // core clock
   input wire presetn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction
   input wire [15:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output wire pready, // apb ready
   output wire pslverr, // apb error on unmapped address
   input wire rx_valid, // frame byte valid
   input wire [7:0] rx_data, // frame byte
   input wire rx_eop, // last byte of frame
   output wire rx_ready, // block takes a byte
   output reg wb_valid, // descriptor result pulse
   output reg [15:0] wb_packet_sum, // packet checksum for the descriptor
   output reg wb_sum_present, // packet sum reported instead of hash
   output reg wb_checksum_error_flag, // checksum error flag
   output wire irq // interrupt level
);
   function [15:0] oc_add;
      input [15:0] a;
      input [15:0] b;
      reg [16:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         oc_add = s[15:0] + {15'h0000, s[16]};
      end
   endfunction

   // control and config registers
   reg [7:0] sum_start_offset_r;
   reg ip_header_check_enable_r;
   reg l4_check_enable_r;
   reg packet_sum_disable_r;
   reg strip_fcs_enable_r;
   reg [15:0] last_sum_r;
   reg last_err_r;

   // stream state
   reg [1:0] state_r;
   reg [7:0] dly0_r, dly1_r, dly2_r, dly3_r;
   reg [3:0] dv_r;
   reg [15:0] pos_r;

   // parser state
   reg [7:0] type_hi_r;
   reg snap_cand_r;
   reg ip_found_r;
   reg [15:0] ip_off_r;
   reg is_v4_r;
   reg [15:0] hdr_len_r;
   reg [15:0] tot_len_r;
   reg frag_r;
   reg [7:0] proto_r;
   reg udp_zero_hi_r;
   reg udp_zero_lo_r;

   wire [15:0] pkt_sum, ip_sum, l4_sum;
   wire [1:0] irq_stat, irq_en;
   wire acc_take = rx_valid && rx_ready;
   wire out_en = dv_r[3] && ((state_r == `ST_RUN && acc_take) || state_r == `ST_FLUSH);
   wire [7:0] b = dly3_r;
   wire [15:0] p = pos_r;
   wire [15:0] rel = p - ip_off_r;
   wire in_ip = ip_found_r && (p >= ip_off_r);
   wire [15:0] l4_rel = rel - hdr_len_r;
   wire [15:0] ihl_len = {10'h000, b[3:0], 2'b00};
   wire ip_byte = in_ip && ((rel == `IPR_VER_IHL) || (rel < hdr_len_r));
   wire addr_byte = in_ip && (rel >= `IPR_ADDR_FIRST) && (rel <= `IPR_ADDR_LAST);
   wire seg_byte = in_ip && is_v4_r && (rel != `IPR_VER_IHL) && (rel >= hdr_len_r) && (rel < tot_len_r);
   wire [15:0] pseudo_word = oc_add({8'h00, proto_r}, tot_len_r - hdr_len_r);
   wire clear_sums = (state_r == `ST_REPORT);

   // packet sum from the start byte onward, over bytes already free of vlan tag
   csum_acc u_pkt_acc (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear_sums),
      .byte_en(out_en && (p >= {8'h00, sum_start_offset_r})),
      .byte_data(b),
      .word_en(1'b0),
      .word_data(16'h0000),
      .sum(pkt_sum)
   );

   // ip header sum
   csum_acc u_ip_acc (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear_sums),
      .byte_en(out_en && ip_byte),
      .byte_data(b),
      .word_en(1'b0),
      .word_data(16'h0000),
      .sum(ip_sum)
   );

   // tcp/udp sum with addresses, protocol and length of the pseudo header
   csum_acc u_l4_acc (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear_sums),
      .byte_en(out_en && (addr_byte || seg_byte)),
      .byte_data(b),
      .word_en(state_r == `ST_PSEUDO),
      .word_data(pseudo_word),
      .sum(l4_sum)
   );

   // stream control: a four byte delay line holds back the possible fcs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= `ST_RUN;
         dly0_r <= 8'h00;
         dly1_r <= 8'h00;
         dly2_r <= 8'h00;
         dly3_r <= 8'h00;
         dv_r <= 4'h0;
         pos_r <= 16'h0000;
      end else begin
         case (state_r)
            `ST_RUN: begin
               if (acc_take) begin
                  dly0_r <= rx_data;
                  dly1_r <= dly0_r;
                  dly2_r <= dly1_r;
                  dly3_r <= dly2_r;
                  if (out_en) begin
                     pos_r <= pos_r + 16'h0001;
                  end
                  if (rx_eop) begin
                     if (strip_fcs_enable_r) begin
                        dv_r <= 4'h0; // last four bytes are the fcs and are dropped
                        state_r <= `ST_PSEUDO;
                     end else begin
                        dv_r <= {dv_r[2:0], 1'b1};
                        state_r <= `ST_FLUSH;
                     end
                  end else begin
                     dv_r <= {dv_r[2:0], 1'b1};
                  end
               end
            end
            `ST_FLUSH: begin
               dly1_r <= dly0_r;
               dly2_r <= dly1_r;
               dly3_r <= dly2_r;
               dv_r <= {dv_r[2:0], 1'b0};
               if (out_en) begin
                  pos_r <= pos_r + 16'h0001;
               end
               if (dv_r[2:0] == 3'h0) begin
                  state_r <= `ST_PSEUDO;
               end
            end
            `ST_PSEUDO: begin
               state_r <= `ST_REPORT;
            end
            `ST_REPORT: begin
               pos_r <= 16'h0000;
               state_r <= `ST_RUN;
            end
            default: begin
               state_r <= `ST_RUN;
            end
         endcase
      end
   end

   assign rx_ready = (state_r == `ST_RUN);

   // frame parser: ethernet ii type at 12, snap llc/oui at 14..19 then type
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         type_hi_r <= 8'h00;
         snap_cand_r <= 1'b0;
         ip_found_r <= 1'b0;
         ip_off_r <= `IP_OFF_ETH2;
         is_v4_r <= 1'b0;
         hdr_len_r <= 16'h0000;
         tot_len_r <= 16'h0000;
         frag_r <= 1'b0;
         proto_r <= 8'h00;
         udp_zero_hi_r <= 1'b0;
         udp_zero_lo_r <= 1'b0;
      end else if (clear_sums) begin
         snap_cand_r <= 1'b0;
         ip_found_r <= 1'b0;
         is_v4_r <= 1'b0;
         hdr_len_r <= 16'h0000;
         tot_len_r <= 16'h0000;
         frag_r <= 1'b0;
         proto_r <= 8'h00;
         udp_zero_hi_r <= 1'b0;
         udp_zero_lo_r <= 1'b0;
      end else if (out_en) begin
         if (p == `POS_TYPE_HI || p == `POS_SNAP_TYPE_HI) begin
            type_hi_r <= b;
         end
         if (p == `POS_TYPE_LO) begin
            if ({type_hi_r, b} == `ETYPE_IPV4) begin
               ip_found_r <= 1'b1;
               ip_off_r <= `IP_OFF_ETH2;
            end
            snap_cand_r <= ({type_hi_r, b} <= `MAX_LEN_FIELD);
         end
         if (snap_cand_r && p >= `POS_SNAP_FIRST && p <= `POS_SNAP_LAST) begin
            if (p <= `POS_SNAP_FIRST + 16'h0001) begin
               if (b != `SNAP_LLC_B0) snap_cand_r <= 1'b0;
            end else if (p == `POS_SNAP_FIRST + 16'h0002) begin
               if (b != `SNAP_LLC_B2) snap_cand_r <= 1'b0;
            end else if (b != `SNAP_OUI_B) begin
               snap_cand_r <= 1'b0;
            end
         end
         if (snap_cand_r && p == `POS_SNAP_TYPE_LO && {type_hi_r, b} == `ETYPE_IPV4) begin
            ip_found_r <= 1'b1;
            ip_off_r <= `IP_OFF_SNAP;
         end
         if (in_ip) begin
            if (rel == `IPR_VER_IHL) begin
               is_v4_r <= (b[7:4] == `IP_VERSION4) && (b[3:0] >= `IP_MIN_IHL);
               hdr_len_r <= ihl_len;
            end
            if (rel == `IPR_LEN_HI) tot_len_r[15:8] <= b;
            if (rel == `IPR_LEN_LO) tot_len_r[7:0] <= b;
            if (rel == `IPR_FRAG_HI && (b[5] || b[4:0] != 5'h00)) frag_r <= 1'b1;
            if (rel == `IPR_FRAG_LO && b != 8'h00) frag_r <= 1'b1;
            if (rel == `IPR_PROTO) proto_r <= b;
            if (seg_byte && l4_rel == `UDP_CSUM_HI) udp_zero_hi_r <= (b == 8'h00);
            if (seg_byte && l4_rel == `UDP_CSUM_LO) udp_zero_lo_r <= (b == 8'h00);
         end
      end
   end

   // pass/fail decision
   wire is_tcp = (proto_r == `PROTO_TCP);
   wire is_udp = (proto_r == `PROTO_UDP);
   wire ip_fail = ip_header_check_enable_r && ip_found_r && is_v4_r && (ip_sum != `SUM_GOOD);
   wire l4_fail = l4_check_enable_r && ip_found_r && is_v4_r && !frag_r && (is_tcp || is_udp) &&
                  (l4_sum != `SUM_GOOD) && !(is_udp && udp_zero_hi_r && udp_zero_lo_r);
   wire err = ip_fail || l4_fail; // either enabled check, none enabled gives zero

   // descriptor write-back; the sum is raw, software does the offsetting
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wb_valid <= 1'b0;
         wb_packet_sum <= 16'h0000;
         wb_sum_present <= 1'b0;
         wb_checksum_error_flag <= 1'b0;
         last_sum_r <= 16'h0000;
         last_err_r <= 1'b0;
      end else begin
         wb_valid <= clear_sums;
         if (clear_sums) begin
            wb_packet_sum <= packet_sum_disable_r ? 16'h0000 : pkt_sum;
            wb_sum_present <= !packet_sum_disable_r;
            wb_checksum_error_flag <= err;
            last_sum_r <= pkt_sum;
            last_err_r <= err;
         end
      end
   end

   // apb slave: zero wait states, read data captured in the setup cycle
   wire setup = psel && !penable;
   wire wr_acc = psel && penable && pwrite;
   wire hit_ctrl = (paddr == `ADDR_CTRL);
   wire hit_stat = (paddr == `ADDR_IRQ_STATUS);
   wire hit_en = (paddr == `ADDR_IRQ_ENABLE);
   wire hit_clr = (paddr == `ADDR_IRQ_CLEAR);
   wire hit_res = (paddr == `ADDR_LAST_RESULT);
   wire hit_cfg = (paddr == `ADDR_RX_CONFIG);
   wire mapped = hit_ctrl || hit_stat || hit_en || hit_clr || hit_res || hit_cfg;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum_start_offset_r <= `CTRL_START_RST;
         ip_header_check_enable_r <= `CTRL_BIT_RST;
         l4_check_enable_r <= `CTRL_BIT_RST;
         packet_sum_disable_r <= `CTRL_BIT_RST;
         strip_fcs_enable_r <= `CTRL_BIT_RST;
      end else if (wr_acc) begin
         if (hit_ctrl) begin
            sum_start_offset_r <= pwdata[`CTRL_START_HI:`CTRL_START_LO];
            ip_header_check_enable_r <= pwdata[`CTRL_IP_EN];
            l4_check_enable_r <= pwdata[`CTRL_L4_EN];
            packet_sum_disable_r <= pwdata[`CTRL_PKT_DIS];
         end
         if (hit_cfg) begin
            strip_fcs_enable_r <= pwdata[`CFG_STRIP_FCS];
         end
      end
   end

   // reserved bits including 11:10 read as zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= 32'h00000000;
         if (!pwrite) begin
            if (hit_ctrl) begin
               prdata[`CTRL_START_HI:`CTRL_START_LO] <= sum_start_offset_r;
               prdata[`CTRL_IP_EN] <= ip_header_check_enable_r;
               prdata[`CTRL_L4_EN] <= l4_check_enable_r;
               prdata[`CTRL_PKT_DIS] <= packet_sum_disable_r;
            end
            if (hit_stat) prdata[1:0] <= irq_stat;
            if (hit_en) prdata[1:0] <= irq_en;
            if (hit_res) begin
               prdata[15:0] <= last_sum_r;
               prdata[`RES_ERR_BIT] <= last_err_r;
            end
            if (hit_cfg) prdata[`CFG_STRIP_FCS] <= strip_fcs_enable_r;
         end
      end
   end

   irq_status u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .event_set({clear_sums && err, clear_sums}),
      .enable_wr(wr_acc && hit_en),
      .clear_wr(wr_acc && hit_clr),
      .wdata(pwdata[1:0]),
      .status(irq_stat),
      .enable(irq_en),
      .irq(irq)
   );
endmodule

// ---- verif/rx_frame_source.sv ----
// source model of the receive frame datapath
// frames come vlan-stripped with the fcs attached; a byte is held until taken
`timescale 1ns/10ps
module rx_frame_source (
   input wire pclk, // core clock
   input wire rx_ready, // byte taken
   output logic rx_valid, // byte valid
   output logic [7:0] rx_data, // byte
   output logic rx_eop // last byte
);
   logic [7:0] mem [0:255];
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_eop = 1'b0;
   end
   // called right after a rising edge; idle data is the inverse of the last byte
   task automatic send(input int n, input bit slow, output bit hung);
      int k;
      bit ok;
      hung = 1'b0;
      for (int i = 0; i < n; i++) begin
         if (slow && 1'($urandom)) begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            @(posedge pclk);
         end
         rx_valid <= 1'b1;
         rx_data <= mem[i];
         rx_eop <= (i == n - 1);
         k = 0;
         do begin
            @(negedge pclk);
            ok = rx_ready;
            @(posedge pclk);
            k++;
         end while (!ok && k < 100);
         if (!ok) hung = 1'b1;
      end
      rx_valid <= 1'b0;
      rx_eop <= 1'b0;
      rx_data <= ~rx_data;
   endtask
endmodule

// ---- verif/rx_checksum_checker.sv ----
// assertions on the ports of the checksum block
// mirrors the control register from apb writes
`timescale 1ns/10ps
`include "rx_checksum_defines.vh"
module rx_checksum_checker (
   input wire pclk, // clock
   input wire presetn, // reset
   input wire psel, // select
   input wire penable, // access
   input wire pwrite, // direction
   input wire [15:0] paddr, // address
   input wire [31:0] pwdata, // wdata
   input wire [31:0] prdata, // rdata
   input wire pready, // ready
   input wire pslverr, // error
   input wire rx_valid, // valid
   input wire rx_eop, // last
   input wire rx_ready, // taken
   input wire wb_valid, // result
   input wire [15:0] wb_packet_sum, // sum
   input wire wb_sum_present, // present
   input wire wb_checksum_error_flag, // flag
   input wire irq // interrupt
);
   reg [13:0] ctrl_r;
   wire acc = psel & penable & pready;
   wire rd = acc & ~pwrite;
   wire mapped = paddr == `ADDR_CTRL || paddr == `ADDR_IRQ_STATUS || paddr == `ADDR_IRQ_ENABLE ||
      paddr == `ADDR_IRQ_CLEAR || paddr == `ADDR_LAST_RESULT || paddr == `ADDR_RX_CONFIG;
   wire eop_take = rx_valid & rx_ready & rx_eop;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 14'h0000;
      end else if (acc && pwrite && paddr == `ADDR_CTRL) begin
         ctrl_r <= pwdata[13:0] & 14'h23ff;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_decode_error: assert property (acc |-> pslverr == !mapped)
      else $error("slave error against decode");
   a_unmapped_zero: assert property (rd && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_readback: assert property (rd && paddr == `ADDR_CTRL |-> prdata == {18'h0, ctrl_r})
      else $error("control readback wrong");
   a_checks_off: assert property (wb_valid && ctrl_r[9:8] == 2'h0 |-> !wb_checksum_error_flag)
      else $error("error flag with checks off");
   a_sum_disable: assert property (wb_valid |-> wb_sum_present == !ctrl_r[13] &&
      (!ctrl_r[13] || wb_packet_sum == 16'h0))
      else $error("packet sum disable ignored");
   a_result_pulse: assert property (wb_valid |=> !wb_valid)
      else $error("result pulse too long");
   a_result_bound: assert property (eop_take |-> ##[2:8] wb_valid)
      else $error("no result after frame end");
   a_result_hold: assert property (!wb_valid |->
      $stable({wb_packet_sum, wb_sum_present, wb_checksum_error_flag}))
      else $error("result changed without pulse");
   a_stall_after_eop: assert property (eop_take |=> !rx_ready)
      else $error("byte taken after frame end");
   a_ready_back: assert property (wb_valid |-> ##[0:2] rx_ready)
      else $error("stream not reopened");
   a_irq_masked: assert property (acc && pwrite && paddr == `ADDR_IRQ_ENABLE && pwdata[1:0] == 2'h0 |=> !irq)
      else $error("interrupt not masked");
   c_error: cover property (wb_valid && wb_checksum_error_flag);
   c_unmapped: cover property (acc && pslverr);
   c_irq: cover property (irq);
endmodule
bind rx_checksum_offload rx_checksum_checker rx_checksum_checker_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_eop(rx_eop), .rx_ready(rx_ready),
   .wb_valid(wb_valid), .wb_packet_sum(wb_packet_sum), .wb_sum_present(wb_sum_present),
   .wb_checksum_error_flag(wb_checksum_error_flag), .irq(irq));

// ---- verif/rx_checksum_offload_tb.sv ----
// self-checking bench for the checksum block
// apb driven here, frames through the source model, one core clock
`timescale 1ns/10ps
`include "rx_checksum_defines.vh"
module rx_checksum_offload_tb;
   logic pclk, presetn, psel, penable, pwrite;
   logic [15:0] paddr;
   logic [31:0] pwdata;
   wire [31:0] prdata;
   wire pready, pslverr, rx_valid, rx_eop, rx_ready, wb_valid, wb_sum_present, wb_checksum_error_flag, irq;
   wire [7:0] rx_data;
   wire [15:0] wb_packet_sum;
   int errors = 0;
   int checks_done = 0;
   logic [7:0] frm [0:255];
   int flen;
   rx_checksum_offload rx_checksum_offload_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eop(rx_eop), .rx_ready(rx_ready),
      .wb_valid(wb_valid), .wb_packet_sum(wb_packet_sum), .wb_sum_present(wb_sum_present),
      .wb_checksum_error_flag(wb_checksum_error_flag), .irq(irq));
   rx_frame_source rx_frame_source_inst (.pclk(pclk), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_eop(rx_eop));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_desc(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic err);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // big-endian words from a, odd last byte padded with zero
   function automatic int rsum(input int a, input int b);
      int s = 0;
      for (int i = a; i < b; i++) s += ((i - a) % 2 == 0) ? {frm[i], 8'h00} : {8'h00, frm[i]};
      return s;
   endfunction
   function automatic logic [15:0] fold(input int s);
      while (s > 32'hffff) s = (s & 32'hffff) + (s >> 16);
      return 16'(s);
   endfunction
   task automatic build(input bit snap, input bit tcp, input bit bi, input bit bl, input int plen);
      int ipo, l4, hl, tot, cp;
      logic [15:0] ck;
      ipo = snap ? 22 : 14;
      l4 = ipo + 20;
      hl = tcp ? 20 : 8;
      tot = 20 + hl + plen;
      flen = ipo + tot + 4;
      for (int i = 0; i < flen; i++) frm[i] = 8'($urandom);
      {frm[12], frm[13]} = snap ? 16'(tot + 8) : `ETYPE_IPV4;
      if (snap) {frm[14], frm[15], frm[16], frm[17], frm[18], frm[19], frm[20], frm[21]} = 64'haaaa030000000800;
      {frm[ipo], frm[ipo + 1], frm[ipo + 6], frm[ipo + 7]} = 32'h45000000;
      {frm[ipo + 2], frm[ipo + 3]} = 16'(tot);
      frm[ipo + 9] = tcp ? `PROTO_TCP : `PROTO_UDP;
      {frm[ipo + 10], frm[ipo + 11]} = 16'h0;
      ck = ~fold(rsum(ipo, l4));
      {frm[ipo + 10], frm[ipo + 11]} = ck;
      cp = l4 + (tcp ? 16 : 6);
      if (tcp) frm[l4 + 12] = 8'h50;
      else {frm[l4 + 4], frm[l4 + 5]} = 16'(hl + plen);
      {frm[cp], frm[cp + 1]} = 16'h0;
      ck = ~fold(rsum(l4, l4 + hl + plen) + rsum(ipo + 12, l4) + frm[ipo + 9] + hl + plen);
      if (!tcp && ck == 16'h0) ck = 16'hffff;
      {frm[cp], frm[cp + 1]} = ck;
      if (bi) frm[ipo + 8] = frm[ipo + 8] + 8'h01;
      if (bl) frm[l4 + hl] = frm[l4 + hl] + 8'h01;
   endtask
   initial begin
      bit snap, tcp, bi, bl, ipe, l4e, strip, dis, slow, hung, ef;
      int st, k;
      logic [31:0] d;
      logic e;
      logic [15:0] es;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      presetn = 1'b0;
      void'($urandom(32'h32d3e292));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADDR_CTRL, 32'h0, d, e);
      chk_reg("ctrl reset", 32'h0, d);
      apb(1'b0, `ADDR_IRQ_STATUS, 32'h0, d, e);
      chk_reg("status reset", 32'h0, d);
      apb(1'b0, 16'h5018, 32'h0, d, e);
      chk_reg("unmapped err", 32'h1, {31'h0, e});
      apb(1'b1, `ADDR_CTRL, 32'hffffffff, d, e);
      apb(1'b0, `ADDR_CTRL, 32'h0, d, e);
      chk_reg("ctrl reserved", 32'h000023ff, d);
      $display("test registers done");
      apb(1'b1, `ADDR_IRQ_ENABLE, 32'h2, d, e);
      for (int i = 0; i < 24; i++) begin
         {snap, tcp, bi, bl, ipe, l4e, strip, dis, slow} = 9'($urandom);
         st = (i < 2) ? 0 : (i == 2) ? 14 : $urandom_range(30);
         build(snap, tcp, bi, bl, 2 + $urandom_range(40));
         for (int j = 0; j < flen; j++) rx_frame_source_inst.mem[j] = frm[j];
         apb(1'b1, `ADDR_CTRL, {18'h0, dis, 3'h0, l4e, ipe, 8'(st)}, d, e);
         apb(1'b1, `ADDR_RX_CONFIG, {31'h0, strip}, d, e);
         rx_frame_source_inst.send(flen, slow, hung);
         k = 0;
         do begin
            @(negedge pclk);
            k++;
         end while (wb_valid !== 1'b1 && k < 50);
         if (hung || wb_valid !== 1'b1) begin
            errors++;
            conclude();
         end
         es = dis ? 16'h0 : fold(rsum(st, flen - (strip ? 4 : 0)));
         ef = (ipe & bi) | (l4e & bl);
         chk_desc("packet sum", es, wb_packet_sum);
         chk_desc("sum present", {15'h0, !dis}, {15'h0, wb_sum_present});
         chk_desc("error flag", 16'(ef), 16'(wb_checksum_error_flag));
         apb(1'b0, `ADDR_LAST_RESULT, 32'h0, d, e);
         chk_reg("last flag", {31'h0, ef}, {31'h0, d[16]});
         apb(1'b0, `ADDR_IRQ_STATUS, 32'h0, d, e);
         chk_reg("status", {30'h0, ef, 1'b1}, d);
         @(negedge pclk);
         chk_reg("irq raised", {31'h0, ef}, {31'h0, irq});
         apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0, d, e);
         @(negedge pclk);
         chk_reg("irq masked", 32'h0, {31'h0, irq});
         apb(1'b1, `ADDR_IRQ_CLEAR, 32'h3, d, e);
         apb(1'b1, `ADDR_IRQ_ENABLE, 32'h2, d, e);
         apb(1'b0, `ADDR_IRQ_STATUS, 32'h0, d, e);
         chk_reg("status cleared", 32'h0, d);
         $display("test frame %0d done", i);
      end
      conclude();
   end
endmodule
